// ### hdl/dmb_pkg.sv
// Constants for the data memory bank addressing block
package dmb_pkg;
   // ==========================================
   // Address map
   localparam logic [11:0] DMB_WREG_BASE = 12'h000;
   localparam logic [11:0] DMB_WREG_LAST = 12'h01f;
   localparam logic [11:0] DMB_BANK0_LAST = 12'h0ff;
   localparam logic [11:0] DMB_BANK1_BASE = 12'h100;
   localparam logic [11:0] DMB_BANK1_LAST = 12'h1ff;
   localparam logic [11:0] DMB_IO_BASE = 12'hf80;
   localparam logic [11:0] DMB_DIRECT_LAST = 12'h07f;
   localparam logic [11:0] DMB_BSC_BASE = 12'hfc0;
   localparam logic [11:0] DMB_BSC_LAST = 12'hfc3;
   localparam logic [3:0] DMB_BANK_IO = 4'hf;
   localparam logic [3:0] DMB_BANK_ONE = 4'h1;
   localparam logic [3:0] DMB_BANK_ZERO = 4'h0;
   localparam logic [15:0] DMB_BSC_RESET = 16'h0000;
   // ==========================================
   // Register indices inside one working bank (low member first)
   localparam logic [2:0] DMB_REG_A = 3'h0;
   localparam logic [2:0] DMB_REG_E = 3'h1;
   localparam logic [2:0] DMB_REG_L = 3'h2;
   localparam logic [2:0] DMB_REG_H = 3'h3;
   localparam logic [2:0] DMB_REG_X = 3'h4;
   localparam logic [2:0] DMB_REG_W = 3'h5;
   localparam logic [2:0] DMB_REG_Z = 3'h6;
   localparam logic [2:0] DMB_REG_Y = 3'h7;
   // ==========================================
   // Access kinds
   typedef enum logic [1:0] {
      DMB_W_BIT,
      DMB_W_NIB,
      DMB_W_BYTE
   } dmb_width_e;
   typedef enum logic [1:0] {
      DMB_M_DIRECT,
      DMB_M_INDIRECT,
      DMB_M_STACK
   } dmb_mode_e;
   // Pointer pairs for indirect access
   typedef enum logic [1:0] {
      DMB_P_PRIMARY,
      DMB_P_SECOND,
      DMB_P_MIXED
   } dmb_ptr_e;
   // Pointer step after the transfer
   typedef enum logic [1:0] {
      DMB_S_NONE,
      DMB_S_INC,
      DMB_S_DEC
   } dmb_step_e;
endpackage : dmb_pkg

// ### hdl/dmb_decode.sv
// Bank and window decoder for data memory accesses
`timescale 1ns/10ps
`default_nettype none
module dmb_decode
   import dmb_pkg::*;
(
   // Bank control
   input wire logic memory_bank_enable_flag,
   input wire logic [3:0] data_bank_select,
   input wire dmb_mode_e mode,
   // Offset inside the bank
   input wire logic [7:0] offset,
   // Decoded result
   output logic [11:0] phys_addr,
   output logic hit_ram,
   output logic hit_bsc
);
   logic [3:0] bank;
   logic window_ok;

   // Bank choice and window limit
   always_comb begin
      bank = DMB_BANK_ZERO;
      window_ok = 1'b1;
      if (mode == DMB_M_STACK) begin
         bank = DMB_BANK_ZERO;
      end else if (memory_bank_enable_flag) begin
         bank = data_bank_select;
      end else if (mode == DMB_M_INDIRECT) begin
         bank = DMB_BANK_ZERO;
      end else begin
         // Direct with flag clear: low 128 of bank 0 or 1, whole page of bank 15
         bank = data_bank_select;
         window_ok = ({4'h0, offset} <= DMB_DIRECT_LAST);
         if (data_bank_select == DMB_BANK_IO) begin
            window_ok = 1'b1; // Low half of page 15 is unmapped anyway
         end
      end
   end

   // Physical address and area hit
   always_comb begin
      phys_addr = {bank, offset};
      hit_ram = 1'b0;
      hit_bsc = 1'b0;
      if (window_ok) begin
         if (phys_addr <= DMB_BANK1_LAST) begin
            hit_ram = 1'b1;
         end
         if (phys_addr >= DMB_BSC_BASE && phys_addr <= DMB_BSC_LAST) begin
            hit_bsc = 1'b1;
         end
      end
   end
endmodule // dmb_decode
`default_nettype wire

// ### hdl/dmb_core.sv
// Data memory with bank decode, working registers and bit carrier
`timescale 1ns/10ps
`default_nettype none
module dmb_core
   import dmb_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Bank control from the CPU
   input wire logic memory_bank_enable_flag,
   input wire logic [3:0] data_bank_select,
   input wire logic register_bank_enable_flag,
   input wire logic [3:0] select_register_bank,
   // Access request
   input wire logic req,
   input wire logic wr,
   input wire dmb_mode_e mode,
   input wire dmb_width_e width,
   input wire dmb_ptr_e ptr_sel,
   input wire dmb_step_e ptr_step,
   input wire logic bsc_bit_seq,
   input wire logic [7:0] addr,
   input wire logic [1:0] bit_sel,
   input wire logic [7:0] wdata,
   // Read answer
   output logic [7:0] rdata,
   output logic rvalid,
   output logic addr_error,
   // Accumulators and pointers
   output logic [3:0] acc_nibble,
   output logic [7:0] wide_accumulator_pair,
   output logic [7:0] primary_pointer_pair,
   output logic [7:0] second_pointer_pair,
   output logic [7:0] mixed_pointer_pair,
   output logic [7:0] spare_register_pair,
   output logic [15:0] bit_sequential_carrier
);
   // ==========================================
   // Storage
   logic [3:0] mem_q [0:511]; // No reset: contents survive reset
   logic [15:0] bsc_q;
   logic [1:0] act_bank;
   logic [4:0] bank_base;
   logic [7:0] ptr_val;
   logic [7:0] eff_off;
   logic [11:0] phys;
   logic hit_ram;
   logic hit_bsc;
   logic [8:0] ram_idx;
   logic [3:0] bsc_bit;
   logic [1:0] bsc_nib;
   logic byte_ok;
   logic [3:0] lo_nib;
   logic [3:0] hi_nib;
   logic [7:0] rd_d;
   logic err_d;
   logic [3:0] l_now;
   logic [3:0] l_next;

   // ==========================================
   // Working register bank select
   always_comb begin
      act_bank = 2'h0;
      if (register_bank_enable_flag) begin
         act_bank = select_register_bank[1:0];
      end
      bank_base = {act_bank, 3'h0};
   end

   // Pointer pair read from the active bank
   always_comb begin
      l_now = mem_q[{4'h0, bank_base | {2'h0, DMB_REG_L}}];
      case (ptr_sel)
         DMB_P_PRIMARY: ptr_val = {mem_q[{4'h0, bank_base | {2'h0, DMB_REG_H}}],
            l_now};
         DMB_P_SECOND: ptr_val = {mem_q[{4'h0, bank_base | {2'h0, DMB_REG_W}}],
            mem_q[{4'h0, bank_base | {2'h0, DMB_REG_X}}]};
         DMB_P_MIXED: ptr_val = {mem_q[{4'h0, bank_base | {2'h0, DMB_REG_W}}],
            l_now};
         default: ptr_val = 8'h00;
      endcase
      l_next = l_now;
      if (ptr_step == DMB_S_INC) begin
         l_next = l_now + 4'h1;
      end else if (ptr_step == DMB_S_DEC) begin
         l_next = l_now - 4'h1;
      end
   end

   // Offset: pointer for indirect, operand otherwise
   always_comb begin
      eff_off = addr;
      if (mode == DMB_M_INDIRECT) begin
         eff_off = ptr_val;
      end
      // Sequential bit mode: the pointer's high register (H, or W for the other pairs) gives the offset's high nibble, L[3:2] the nibble
      if (bsc_bit_seq && mode == DMB_M_INDIRECT) begin
         eff_off = {ptr_val[7:4], 2'h0, l_now[3:2]};
      end
      if (width == DMB_W_BYTE) begin
         eff_off[0] = 1'b0;
      end
   end

   dmb_decode u_decode (
      .memory_bank_enable_flag(memory_bank_enable_flag),
      .data_bank_select(data_bank_select),
      .mode(mode),
      .offset(eff_off),
      .phys_addr(phys),
      .hit_ram(hit_ram),
      .hit_bsc(hit_bsc)
   );

   // ==========================================
   // Local indexes
   always_comb begin
      ram_idx = phys[8:0];
      bsc_nib = phys[1:0];
      bsc_bit = {bsc_nib, bit_sel};
      if (bsc_bit_seq && mode == DMB_M_INDIRECT) begin
         bsc_bit = l_now;
         bsc_nib = l_now[3:2];
      end
      byte_ok = (width != DMB_W_BYTE) || (phys[11:1] != 11'h7e1) ||
         (phys[1:0] == 2'h0) || (phys[1:0] == 2'h2);
      lo_nib = hit_ram ? mem_q[ram_idx] : bsc_q[{bsc_nib, 2'h0} +: 4];
      hi_nib = hit_ram ? mem_q[{ram_idx[8:1], 1'b1}]
         : bsc_q[{bsc_nib[1], 1'b1, 2'h0} +: 4];
   end

   // Read data selection
   always_comb begin
      rd_d = 8'h00;
      err_d = !(hit_ram || hit_bsc);
      if (hit_ram || hit_bsc) begin
         case (width)
            DMB_W_BIT: rd_d = hit_bsc ? {7'h00, bsc_q[bsc_bit]}
               : {7'h00, lo_nib[bit_sel]};
            DMB_W_NIB: rd_d = {4'h0, lo_nib};
            DMB_W_BYTE: rd_d = {hi_nib, lo_nib};
            default: rd_d = 8'h00;
         endcase
      end
   end

   // ==========================================
   // RAM writes and pointer step, never touched by reset
   always_ff @(posedge clock) begin
      if (req && wr && hit_ram) begin
         case (width)
            DMB_W_BIT: mem_q[ram_idx][bit_sel] <= wdata[0];
            DMB_W_NIB: mem_q[ram_idx] <= wdata[3:0];
            DMB_W_BYTE: begin
               mem_q[ram_idx] <= wdata[3:0];
               mem_q[{ram_idx[8:1], 1'b1}] <= wdata[7:4];
            end
            default: mem_q[ram_idx] <= mem_q[ram_idx];
         endcase
      end
      if (req && mode == DMB_M_INDIRECT && ptr_sel == DMB_P_PRIMARY &&
         ptr_step != DMB_S_NONE) begin
         mem_q[{4'h0, bank_base | {2'h0, DMB_REG_L}}] <= l_next;
      end
   end

   // Carrier register
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         bsc_q <= DMB_BSC_RESET;
      end else if (req && wr && hit_bsc && byte_ok) begin
         case (width)
            DMB_W_BIT: bsc_q[bsc_bit] <= wdata[0];
            DMB_W_NIB: bsc_q[{bsc_nib, 2'h0} +: 4] <= wdata[3:0];
            DMB_W_BYTE: bsc_q[{bsc_nib[1], 3'h0} +: 8] <= wdata;
            default: bsc_q <= bsc_q;
         endcase
      end
   end

   // Read answer registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rdata <= 8'h00;
         rvalid <= 1'b0;
         addr_error <= 1'b0;
      end else begin
         rvalid <= req && !wr;
         addr_error <= req && err_d;
         if (req && !wr) begin
            rdata <= rd_d;
         end
      end
   end

   // Accumulator and pair views of the active bank
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         acc_nibble <= 4'h0;
         wide_accumulator_pair <= 8'h00;
         primary_pointer_pair <= 8'h00;
         second_pointer_pair <= 8'h00;
         mixed_pointer_pair <= 8'h00;
         spare_register_pair <= 8'h00;
         bit_sequential_carrier <= DMB_BSC_RESET;
      end else begin
         acc_nibble <= mem_q[{4'h0, bank_base}];
         wide_accumulator_pair <= {mem_q[{4'h0, bank_base | 5'h1}],
            mem_q[{4'h0, bank_base}]};
         primary_pointer_pair <= {mem_q[{4'h0, bank_base | 5'h3}],
            mem_q[{4'h0, bank_base | 5'h2}]};
         second_pointer_pair <= {mem_q[{4'h0, bank_base | 5'h5}],
            mem_q[{4'h0, bank_base | 5'h4}]};
         mixed_pointer_pair <= {mem_q[{4'h0, bank_base | 5'h5}],
            mem_q[{4'h0, bank_base | 5'h2}]};
         spare_register_pair <= {mem_q[{4'h0, bank_base | 5'h7}],
            mem_q[{4'h0, bank_base | 5'h6}]};
         bit_sequential_carrier <= bsc_q;
      end
   end
endmodule // dmb_core
`default_nettype wire

// ### sim/dmb_core_asserts.sv
// Port assertions for the data memory bank core
`timescale 1ns/10ps
`default_nettype none
module dmb_core_asserts
   import dmb_pkg::*;
(
   // Clock, reset and request
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic memory_bank_enable_flag,
   input wire logic [3:0] data_bank_select,
   input wire logic req,
   input wire logic wr,
   input wire dmb_mode_e mode,
   input wire logic bsc_bit_seq,
   input wire logic [7:0] addr,
   // Answers and views
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   input wire logic addr_error,
   input wire logic [3:0] acc_nibble,
   input wire logic [7:0] wide_accumulator_pair,
   input wire logic [15:0] bit_sequential_carrier
);
   // ==========================================
   // Properties, all in the one clock domain
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   property p_rvalid; rvalid |-> $past(req && !wr); endproperty
   a_rvalid: assert property (p_rvalid) else $error("stray rvalid");
   property p_err_zero; addr_error && $past(!wr) |-> rdata == 8'h00;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("bad rdata");
   property p_direct; req && mode == DMB_M_DIRECT && !memory_bank_enable_flag
      && data_bank_select[3:1] == 3'h0 && addr > 8'h7f |=> addr_error;
   endproperty
   a_direct: assert property (p_direct) else $error("window open");
   property p_stack; req && mode == DMB_M_STACK |=> !addr_error; endproperty
   a_stack: assert property (p_stack) else $error("stack refused");
   property p_indir; req && mode == DMB_M_INDIRECT && !bsc_bit_seq
      && !memory_bank_enable_flag |=> !addr_error; endproperty
   a_indir: assert property (p_indir) else $error("indirect refused");
   property p_bank; req && memory_bank_enable_flag && mode != DMB_M_STACK
      && data_bank_select inside {[4'h2:4'he]} |=> addr_error; endproperty
   a_bank: assert property (p_bank) else $error("empty bank hit");
   property p_acc; wide_accumulator_pair[3:0] === acc_nibble; endproperty
   a_acc: assert property (p_acc) else $error("acc pair split");
   property p_bsc_rst; $fell(sys_rst) |-> bit_sequential_carrier == 16'h0000;
   endproperty
   a_bsc_rst: assert property (p_bsc_rst) else $error("carrier kept");
endmodule // dmb_core_asserts
bind dmb_core dmb_core_asserts u_chk (.clock, .sys_rst,
   .memory_bank_enable_flag, .data_bank_select, .req, .wr, .mode,
   .bsc_bit_seq, .addr, .rdata, .rvalid, .addr_error, .acc_nibble,
   .wide_accumulator_pair, .bit_sequential_carrier);
`default_nettype wire

// ### sim/dmb_cpu_model.sv
// CPU side model issuing data memory accesses
`timescale 1ns/10ps
`default_nettype none
module dmb_cpu_model
   import dmb_pkg::*;
(
   // Clock
   input wire logic clock,
   // Bank control and request
   output logic memory_bank_enable_flag,
   output logic [3:0] data_bank_select,
   output logic register_bank_enable_flag,
   output logic [3:0] select_register_bank,
   output logic req,
   output logic wr,
   output var dmb_mode_e mode,
   output var dmb_width_e width,
   output var dmb_ptr_e ptr_sel,
   output var dmb_step_e ptr_step,
   output logic bsc_bit_seq,
   output logic [7:0] addr,
   output logic [1:0] bit_sel,
   output logic [7:0] wdata
);
   // ==========================================
   // Idle values
   initial begin
      {memory_bank_enable_flag, data_bank_select, req, wr} = '0;
      {register_bank_enable_flag, select_register_bank, bsc_bit_seq} = '0;
      {mode, width, ptr_sel, ptr_step, addr, bit_sel, wdata} = '0;
   end
   // One access: held through the taking edge, then released
   task automatic acc(input int f, s, rf, rs, w, m, wd, p, st, a, b, d, q);
      @(posedge clock);
      #1;
      memory_bank_enable_flag = f[0];
      data_bank_select = s[3:0];
      register_bank_enable_flag = rf[0];
      select_register_bank = {2'h0, rs[1:0]};
      wr = w[0];
      mode = dmb_mode_e'(m[1:0]);
      width = dmb_width_e'(wd[1:0]);
      ptr_sel = dmb_ptr_e'(p[1:0]);
      ptr_step = dmb_step_e'(st[1:0]);
      addr = a[7:0];
      bit_sel = b[1:0];
      bsc_bit_seq = q[0];
      wdata = d[7:0];
      req = 1'b1;
      @(posedge clock);
      #1;
      req = 1'b0;
      wdata = ~d[7:0];
   endtask
endmodule // dmb_cpu_model
`default_nettype wire

// ### sim/data_memory_bank_addressing_test.sv
// Self-checking bench for the data memory bank core
`timescale 1ns/10ps
`default_nettype none
`define CK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
   $display("CHECK FAILED %0t got %h want %h", $time, g, e); end end
module data_memory_bank_addressing_test import dmb_pkg::*;;
   logic clock = 1'b0, sys_rst = 1'b1, memory_bank_enable_flag, req, wr;
   logic register_bank_enable_flag, bsc_bit_seq, rvalid, addr_error;
   logic [3:0] data_bank_select, select_register_bank, acc_nibble;
   logic [7:0] addr, wdata, rdata, wide_accumulator_pair;
   logic [1:0] bit_sel;
   logic [15:0] bit_sequential_carrier;
   logic [7:0] primary_pointer_pair, second_pointer_pair;
   logic [7:0] mixed_pointer_pair, spare_register_pair;
   dmb_mode_e mode;
   dmb_width_e width;
   dmb_ptr_e ptr_sel;
   dmb_step_e ptr_step;
   int mem[4096], n_fail = 0, comparisons = 0, cyc = 0, seed = 67395;
   int sels[4] = '{0, 1, 2, 15};
   int offs[8] = '{2, 3, 'h10, 'h7f, 'h80, 'h40, 'h42, 'hc1};
   // ==========================================
   // Clock, watchdog and parts
   always #50 clock = ~clock;
   always @(posedge clock) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         test_done;
      end
   end
   dmb_cpu_model cpu (.clock, .memory_bank_enable_flag, .data_bank_select,
      .register_bank_enable_flag, .select_register_bank, .req, .wr, .mode,
      .width, .ptr_sel, .ptr_step, .bsc_bit_seq, .addr, .bit_sel, .wdata);
   dmb_core dut (.clock, .sys_rst, .memory_bank_enable_flag, .data_bank_select,
      .register_bank_enable_flag, .select_register_bank, .req, .wr, .mode,
      .width, .ptr_sel, .ptr_step, .bsc_bit_seq, .addr, .bit_sel, .wdata,
      .rdata, .rvalid, .addr_error, .acc_nibble, .wide_accumulator_pair,
      .primary_pointer_pair, .second_pointer_pair, .mixed_pointer_pair,
      .spare_register_pair, .bit_sequential_carrier);
   // ==========================================
   // Reference map: -1 unmapped, -2 not predicted
   function automatic int phys(int f, int s, int m, int o);
      if (m == 2 || (!f && m == 1)) return o;
      if (f) o += s * 256;
      else if (s == 15) o += 'hf00;
      else if (o > 'h7f) return -1;
      else o += s * 256;
      return (o < 'h200 || (o >= 'hfc0 && o <= 'hfc3)) ? o : -1;
   endfunction
   // Reset; memory kept, carrier cleared
   task automatic do_reset;
      @(posedge clock);
      #1;
      sys_rst = 1'b1;
      repeat (4) @(posedge clock);
      #1;
      sys_rst = 1'b0;
      for (int k = 'hfc0; k <= 'hfc3; k++) mem[k] = 0;
   endtask
   task automatic test_done;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ==========================================
   // Random accesses against the model
   initial begin
      logic [31:0] r;
      int f, s, rf, rs, w, m, wd, p, st, a, b, d, base, ptr, e, v;
      foreach (mem[k]) mem[k] = -1;
      do_reset;
      for (int i = 0; i < 400; i++) begin
         if (i == 200) do_reset;
         r = $random(seed);
         f = r[0];
         s = sels[r[2:1]];
         rf = r[3];
         rs = r[5:4];
         w = r[6];
         a = offs[r[9:7]];
         m = r[11:10] % 3;
         wd = r[13:12] % 3;
         p = r[15:14] % 3;
         st = r[17:16] % 3;
         b = r[19:18];
         d = r[27:20];
         base = rf ? rs * 8 : 0;
         ptr = mem[base + (p == 0 ? 3 : 5)] * 16 + mem[base + (p == 1 ? 4 : 2)];
         if (m == 1 && (mem[base + (p == 0 ? 3 : 5)] < 0
            || mem[base + (p == 1 ? 4 : 2)] < 0)) m = 0;
         e = phys(f, s, m, (m == 1 ? ptr : a) & (wd == 2 ? 'hfe : 'hff));
         cpu.acc(f, s, rf, rs, w, m, wd, p, st, a, b, d, 0);
         if (e != -2) `CK(addr_error, 1'(e < 0))
         if (e >= 0 && !w) begin
            `CK(rvalid, 1'b1)
            v = wd == 2 ? mem[e + 1] * 16 + mem[e] : wd == 1 ? mem[e]
               : (mem[e] >> b) & 1;
            if (mem[e] >= 0 && (wd != 2 || mem[e + 1] >= 0))
               `CK(rdata, 8'(v))
         end else if (e >= 0) begin
            if (wd == 2) {mem[e], mem[e + 1]} = {d & 15, d >> 4};
            else if (wd == 1) mem[e] = d & 15;
            else if (mem[e] >= 0)
               mem[e] = mem[e] & ~(1 << b) | (d & 1) << b;
         end
         if (m == 1 && p == 0 && st != 0)
            mem[base + 2] = (e < 0 || e == base + 2) ? -1
               : (mem[base + 2] + (st == 1 ? 1 : 15)) & 15;
         @(posedge clock);
         #1;
         `CK(bit_sequential_carrier, 16'(mem['hfc3] << 12 | mem['hfc2] << 8
            | mem['hfc1] << 4 | mem['hfc0]))
         if (mem[base] >= 0 && mem[base + 1] >= 0)
            `CK(wide_accumulator_pair, 8'(mem[base + 1] * 16 + mem[base]))
         if (mem[base + 3] >= 0 && mem[base + 2] >= 0)
            `CK(primary_pointer_pair, 8'(mem[base + 3] * 16 + mem[base + 2]))
         if (mem[base + 5] >= 0 && mem[base + 4] >= 0)
            `CK(second_pointer_pair, 8'(mem[base + 5] * 16 + mem[base + 4]))
         if (mem[base + 5] >= 0 && mem[base + 2] >= 0)
            `CK(mixed_pointer_pair, 8'(mem[base + 5] * 16 + mem[base + 2]))
         if (mem[base + 7] >= 0 && mem[base + 6] >= 0)
            `CK(spare_register_pair, 8'(mem[base + 7] * 16 + mem[base + 6]))
      end
      // Walk all 16 carrier bits through L, H pointing at the carrier
      cpu.acc(0, 0, 0, 0, 1, 0, 1, 0, 0, 3, 0, 'hc, 0);
      cpu.acc(0, 0, 0, 0, 1, 0, 1, 0, 0, 2, 0, 0, 0);
      for (int k = 0; k < 16; k++)
         cpu.acc(1, 15, 0, 0, 1, 1, 0, 0, 1, 0, 0, k & 1, 1);
      for (int k = 0; k < 2; k++) begin
         cpu.acc(1, 15, 0, 0, 0, 1, 0, 0, 1, 0, 0, 0, 1);
         `CK(rdata, 8'(k))
      end
      @(posedge clock);
      #1;
      `CK(bit_sequential_carrier, 16'haaaa)
      `CK(primary_pointer_pair, 8'hc2)
      test_done;
   end
endmodule // data_memory_bank_addressing_test
`default_nettype wire
